// file: pkg/pwm_bridge_defines.svh
// field positions, reset values and timing counts of the bridge modulator
// assumes it is included by bare name from the package and the design modules
`ifndef PWM_BRIDGE_DEFINES_SVH
`define PWM_BRIDGE_DEFINES_SVH

// control register reset value and field positions
`define PWB_CTRL_RST      8'h00
`define PWB_OUTMODE_HI    7
`define PWB_OUTMODE_LO    6
`define PWB_DUTYLSB_HI    5
`define PWB_DUTYLSB_LO    4
`define PWB_FUNC_HI       3
`define PWB_FUNC_LO       0
`define PWB_POL_AC_BIT    1
`define PWB_POL_BD_BIT    0

// function field encodings
`define PWB_FUNC_PWM      2'h3
`define PWB_FUNC_SPECIAL  4'hB

// timing: oscillator cycles per timer increment before prescaling
`define PWB_OSC_PER_TICK  4

// other reset values
`define PWB_DUTY_RST      10'h000
`define PWB_PERIOD_RST    8'h00
`define PWB_CMP_RST       16'h0000

`endif

// file: pkg/pwm_bridge_pkg.sv
// types shared by the bridge modulator and its compare trigger
// assumes the defines header sits on the include path
`include "pwm_bridge_defines.svh"

package pwm_bridge_pkg;

  // output steering selected by the top two control bits
  typedef enum logic [1:0] {
    BR_SINGLE   = 2'b00,
    BR_FULL_FWD = 2'b01,
    BR_HALF     = 2'b10,
    BR_FULL_REV = 2'b11
  } bridge_mode_e;

endpackage : pwm_bridge_pkg

// file: hdl/compare_trigger.sv
// compare timer with special-event trigger
// assumes enable, compare value and adc_enabled come from logic on mclk
`timescale 1ns/1ns
`include "pwm_bridge_defines.svh"
`default_nettype none

module compare_trigger
  import pwm_bridge_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // configuration
  input  wire logic        enable,
  input  wire logic [15:0] cmp_value,
  input  wire logic [1:0]  prescale_sel,
  input  wire logic        adc_enabled,
  // events and state
  output var  logic        trig_irq,
  output var  logic        adc_start,
  output var  logic [15:0] timer_q
);

  logic [4:0]  pre_r;
  logic        tick;
  logic [15:0] timer_nxt;
  logic        fire;

  // prescale 1,2,4,8 on top of the fixed four oscillator cycles
  function automatic logic [4:0] cmp_pre_last(input logic [1:0] sel);
    cmp_pre_last = 5'((`PWB_OSC_PER_TICK << sel) - 1);
  endfunction : cmp_pre_last

  assign tick      = enable && (pre_r == cmp_pre_last(prescale_sel));
  assign timer_nxt = timer_q + 16'h0001;
  // R8: match on compare value
  assign fire      = tick && (timer_nxt == cmp_value);

  // prescaler
  always_ff @(posedge mclk) begin
    if (!nrst || !enable || tick) begin
      pre_r <= 5'h00;
    end else begin
      pre_r <= pre_r + 5'h01;
    end
  end

  // R9: timer cleared on match
  always_ff @(posedge mclk) begin
    if (!nrst || !enable) begin
      timer_q <= `PWB_CMP_RST;
    end else if (fire) begin
      timer_q <= 16'h0000;
    end else if (tick) begin
      timer_q <= timer_nxt;
    end
  end

  // R9: interrupt and conversion start pulses
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      trig_irq  <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      trig_irq  <= fire;
      adc_start <= fire && adc_enabled;
    end
  end

  property p_fire_clears;
    @(posedge mclk) disable iff (!nrst)
      (enable && tick && timer_nxt == cmp_value) |=> trig_irq && timer_q == 16'h0000;
  endproperty
  a_fire_clears: assert property (p_fire_clears) else $error("match did not fire"); // R8

  property p_adc_gate;
    @(posedge mclk) disable iff (!nrst)
      adc_start |-> trig_irq && $past(adc_enabled);
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("conversion start not gated"); // R9

endmodule : compare_trigger

`default_nettype wire

// file: hdl/enhanced_pwm_bridge_output.sv
// ten-bit bridge pulse-width modulator with period timer and pin steering
// assumes software-side inputs are driven by logic on mclk, pins are tri-state
//
// Behaviour
// R1: primary output carries a pulse-width waveform with ten-bit duty resolution.
// R2: modulated signal can be routed onto any of four bridge outputs a to d; the code routes it to a, b or d only, never to c.
// R3: modes single, half-bridge, full-bridge forward and full-bridge reverse.
// R4: pairs a/c and b/d each independently active-high or active-low.
// R5: period is (period limit + 1) * 4 * prescale oscillator cycles.
// R6: duty is duty high byte joined with control bits 5:4 below.
// R7: writing control with the modulation function enables output, keeping duty lsbs.
// R8: special-event submode raises a trigger when compare timer reaches compare value.
// R9: on that match raise interrupt, clear compare timer, start conversion if enabled.
// R10: output active at period start, inactive when extended timer reaches duty.
// R11: new duty takes effect only at the next period boundary.
`timescale 1ns/1ns
`include "pwm_bridge_defines.svh"
`default_nettype none

module enhanced_pwm_bridge_output
  import pwm_bridge_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // control register write
  input  wire logic       ctrl_wr,
  input  wire logic [7:0] ctrl_wdata,
  // modulator settings
  input  wire logic [7:0] duty_high_byte,
  input  wire logic [7:0] period_limit_reg,
  input  wire logic [1:0] tmr_prescale_sel,
  // compare trigger settings
  input  wire logic [7:0] compare_low_byte,
  input  wire logic [7:0] compare_high_byte,
  input  wire logic [1:0] cmp_prescale_sel,
  input  wire logic       adc_enabled,
  // bridge pins
  output var  logic       bridge_out_a,
  output var  logic       bridge_out_b,
  output var  logic       bridge_out_c,
  output var  logic       bridge_out_d,
  output var  logic       bridge_oe_a,
  output var  logic       bridge_oe_b,
  output var  logic       bridge_oe_c,
  output var  logic       bridge_oe_d,
  // status and events
  output var  logic [7:0] module_control_reg,
  output var  logic [7:0] period_timer,
  output var  logic       module_irq,
  output var  logic       adc_start
);

  logic [7:0]   pre_r;
  logic [9:0]   duty_act_r;
  logic         mod_r;
  logic         pwm_en;
  logic         tick;
  logic         boundary;
  logic         period_start;
  logic [9:0]   duty_nxt;
  logic [9:0]   ext_timer;
  logic         ac_low;
  logic         bd_low;
  bridge_mode_e mode;

  // last prescaler count: 4, 16, 64 or 256 oscillator cycles per timer step
  function automatic logic [7:0] pre_last(input logic [1:0] sel);
    pre_last = 8'((`PWB_OSC_PER_TICK << (2 * sel)) - 1);
  endfunction : pre_last

  // two prescaler bits that extend the timer to ten bits
  function automatic logic [1:0] fine_bits(input logic [7:0] cnt, input logic [1:0] sel);
    unique case (sel)
      2'h0: fine_bits = cnt[1:0];
      2'h1: fine_bits = cnt[3:2];
      2'h2: fine_bits = cnt[5:4];
      2'h3: fine_bits = cnt[7:6];
    endcase
  endfunction : fine_bits

  assign pwm_en       = module_control_reg[`PWB_FUNC_HI:2] == `PWB_FUNC_PWM;
  assign mode         = bridge_mode_e'(module_control_reg[`PWB_OUTMODE_HI:`PWB_OUTMODE_LO]);
  assign ac_low       = module_control_reg[`PWB_POL_AC_BIT];
  assign bd_low       = module_control_reg[`PWB_POL_BD_BIT];
  assign tick         = pwm_en && (pre_r == pre_last(tmr_prescale_sel));
  assign boundary     = tick && (period_timer == period_limit_reg);
  assign period_start = pwm_en && (pre_r == 8'h00) && (period_timer == 8'h00);
  // R1: ten-bit compare timer
  assign ext_timer    = {period_timer, fine_bits(pre_r, tmr_prescale_sel)};
  // R6: duty from high byte and lsb field; a write in flight is seen at once
  assign duty_nxt     = {duty_high_byte, ctrl_wr ? ctrl_wdata[`PWB_DUTYLSB_HI:`PWB_DUTYLSB_LO]
                                                 : module_control_reg[`PWB_DUTYLSB_HI:`PWB_DUTYLSB_LO]};

  // R7: control register written whole, lsbs stay with it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      module_control_reg <= `PWB_CTRL_RST;
    end else if (ctrl_wr) begin
      module_control_reg <= ctrl_wdata;
    end
  end

  // R5: prescaler of four times the selected factor
  always_ff @(posedge mclk) begin
    if (!nrst || !pwm_en || tick) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  // R5: period timer wraps after the period limit
  always_ff @(posedge mclk) begin
    if (!nrst || !pwm_en || boundary) begin
      period_timer <= `PWB_PERIOD_RST;
    end else if (tick) begin
      period_timer <= period_timer + 8'h01;
    end
  end

  // R11: duty buffered, reloaded only at a boundary or while idle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      duty_act_r <= `PWB_DUTY_RST;
    end else if (!pwm_en || boundary) begin
      duty_act_r <= duty_nxt;
    end
  end

  // R10: set at period start, clear on duty match; duty above period gives 100 %
  always_ff @(posedge mclk) begin
    if (!nrst || !pwm_en) begin
      mod_r <= 1'b0;
    end else if (period_start) begin
      mod_r <= duty_act_r != 10'h000;
    end else if (ext_timer == duty_act_r) begin
      mod_r <= 1'b0;
    end
  end

  // R2: pin steering, registered so every pin comes from a flip-flop
  // R3: unused pins float; inactive bridge legs are driven to their off level
  // R4: polarity applied per pair by xor with the low-active bits
  always_ff @(posedge mclk) begin
    if (!nrst || !pwm_en) begin
      {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <= 4'h0;
      {bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d}     <= 4'h0;
    end else begin
      unique case (mode)
        BR_SINGLE: begin
          {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <= {mod_r ^ ac_low, 3'h0};
          {bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d}     <= 4'h8;
        end
        BR_HALF: begin
          // no dead band: b is the plain complement of mod_r, each leg with its own pair polarity
          {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <=
            {mod_r ^ ac_low, ~mod_r ^ bd_low, 2'h0};
          {bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d}     <= 4'hC;
        end
        BR_FULL_FWD: begin
          {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <=
            {~ac_low, bd_low, ac_low, mod_r ^ bd_low};
          {bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d}     <= 4'hF;
        end
        BR_FULL_REV: begin
          {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <=
            {ac_low, mod_r ^ bd_low, ~ac_low, bd_low};
          {bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d}     <= 4'hF;
        end
      endcase
    end
  end

  // R8: compare special-event trigger
  compare_trigger u_cmp (
    .mclk         (mclk),
    .nrst         (nrst),
    .enable       (module_control_reg[`PWB_FUNC_HI:`PWB_FUNC_LO] == `PWB_FUNC_SPECIAL),
    .cmp_value    ({compare_high_byte, compare_low_byte}),
    .prescale_sel (cmp_prescale_sel),
    .adc_enabled  (adc_enabled),
    .trig_irq     (module_irq),
    .adc_start    (adc_start),
    .timer_q      ()
  );

  // helper: cycles since last boundary, valid while settings stay fixed
  logic [17:0] since_r;
  logic [17:0] exp_len;
  logic        len_ok_r;
  logic [7:0]  per_q;
  logic [1:0]  sel_q;
  assign exp_len = ({10'h000, period_limit_reg} + 18'h00001) *
                   ({10'h000, pre_last(tmr_prescale_sel)} + 18'h00001);
  always_ff @(posedge mclk) begin
    per_q <= period_limit_reg;
    sel_q <= tmr_prescale_sel;
    since_r <= (!nrst || boundary) ? 18'h00000 : since_r + 18'h00001;
    if (!nrst || !pwm_en || per_q != period_limit_reg || sel_q != tmr_prescale_sel) begin
      len_ok_r <= 1'b0;
    end else if (boundary) begin
      len_ok_r <= 1'b1;
    end
  end

  property p_period_len;
    @(posedge mclk) disable iff (!nrst)
      (boundary && len_ok_r && per_q == period_limit_reg && sel_q == tmr_prescale_sel) |->
        since_r + 18'h00001 == exp_len;
  endproperty
  a_period_len: assert property (p_period_len) else $error("period length wrong"); // R5

  property p_duty_load;
    @(posedge mclk) disable iff (!nrst)
      (pwm_en && boundary) |=> duty_act_r == $past(duty_nxt);
  endproperty
  a_duty_load: assert property (p_duty_load) else $error("duty not loaded at boundary"); // R11

  property p_duty_hold;
    @(posedge mclk) disable iff (!nrst)
      (pwm_en && !boundary && !ctrl_wr) |=> $stable(duty_act_r) || !$past(pwm_en, 1);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty changed mid period"); // R11

  sequence s_start;
    period_start && duty_act_r != 10'h000;
  endsequence
  sequence s_match;
    pwm_en && !period_start && mod_r && ext_timer == duty_act_r;
  endsequence

  property p_rise;
    @(posedge mclk) disable iff (!nrst)
      s_start |=> mod_r;
  endproperty
  a_rise: assert property (p_rise) else $error("no active edge at period start"); // R10

  property p_fall;
    @(posedge mclk) disable iff (!nrst)
      s_match |=> !mod_r;
  endproperty
  a_fall: assert property (p_fall) else $error("no inactive edge at duty match"); // R10

  property p_single;
    @(posedge mclk) disable iff (!nrst)
      (pwm_en && mode == BR_SINGLE && !ac_low) |=>
        bridge_oe_a && !bridge_oe_b && !bridge_oe_c && !bridge_oe_d &&
        bridge_out_a == $past(mod_r);
  endproperty
  a_single: assert property (p_single) else $error("single mode pins wrong"); // R1

  property p_full_fwd;
    @(posedge mclk) disable iff (!nrst)
      (pwm_en && mode == BR_FULL_FWD) |=>
        bridge_out_a == !$past(ac_low) && bridge_out_d == ($past(mod_r) ^ $past(bd_low));
  endproperty
  a_full_fwd: assert property (p_full_fwd) else $error("forward steering wrong"); // R4

  property p_full_rev;
    @(posedge mclk) disable iff (!nrst)
      (pwm_en && mode == BR_FULL_REV) |=>
        bridge_out_c == !$past(ac_low) && bridge_out_b == ($past(mod_r) ^ $past(bd_low));
  endproperty
  a_full_rev: assert property (p_full_rev) else $error("reverse steering wrong"); // R3

  property p_enable;
    @(posedge mclk) disable iff (!nrst)
      (ctrl_wr && ctrl_wdata[3:2] == 2'h3) |-> ##2 bridge_oe_a;
  endproperty
  a_enable: assert property (p_enable) else $error("write did not enable output"); // R7

  property p_irq_route;
    @(posedge mclk) disable iff (!nrst)
      adc_start |-> module_irq;
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("start without interrupt"); // R9

endmodule : enhanced_pwm_bridge_output

`default_nettype wire

// file: tb/bridge_load_model.sv
// far-side load: gate drivers with pull-downs on the four bridge legs
// assumes pin levels and enables come straight from the modulator
`timescale 1ns/1ns
`default_nettype none

module bridge_load_model (
  // pin drive from the modulator
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // levels seen by the drivers
  output logic      [3:0] drv_lvl
);
  // a released leg is pulled low, so its driver stays off instead of floating
  assign drv_lvl = pin_out & pin_oe;
endmodule : bridge_load_model

`default_nettype wire

// file: tb/enhanced_pwm_bridge_output_bench.sv
// self-checking bench for the bridge modulator and its compare trigger
// assumes a 100 MHz clock and inputs driven 1 ns after each rising edge
`timescale 1ns/1ns
`default_nettype none

module enhanced_pwm_bridge_output_bench
  import pwm_bridge_pkg::*;
;
  logic       mclk, nrst, ctrl_wr, adc_enabled, module_irq, adc_start;
  logic [7:0] ctrl_wdata, duty_high_byte, period_limit_reg, module_control_reg;
  logic [7:0] compare_low_byte, compare_high_byte, period_timer, exp8, nh;
  logic [1:0] tmr_prescale_sel, cmp_prescale_sel;
  wire logic [3:0] pin_out, pin_oe;
  logic [3:0] drv_lvl;
  logic [9:0] d10;
  logic [15:0] cv;
  int         fails, total_checks, hi, per, cnt, lim, sel, f;

  enhanced_pwm_bridge_output dut (
    .mclk(mclk), .nrst(nrst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .duty_high_byte(duty_high_byte), .period_limit_reg(period_limit_reg),
    .tmr_prescale_sel(tmr_prescale_sel), .compare_low_byte(compare_low_byte),
    .compare_high_byte(compare_high_byte), .cmp_prescale_sel(cmp_prescale_sel),
    .adc_enabled(adc_enabled), .bridge_out_a(pin_out[3]), .bridge_out_b(pin_out[2]),
    .bridge_out_c(pin_out[1]), .bridge_out_d(pin_out[0]), .bridge_oe_a(pin_oe[3]),
    .bridge_oe_b(pin_oe[2]), .bridge_oe_c(pin_oe[1]), .bridge_oe_d(pin_oe[0]),
    .module_control_reg(module_control_reg), .period_timer(period_timer),
    .module_irq(module_irq), .adc_start(adc_start));

  bridge_load_model load (.pin_out(pin_out), .pin_oe(pin_oe), .drv_lvl(drv_lvl));

  // free-running system clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : check

  // every step lands 1 ns after the edge, so inputs never race the sampling
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask : tick

  task automatic write_ctrl(input logic [7:0] v);
    ctrl_wdata = v;
    ctrl_wr    = 1'b1;
    tick(1);
    ctrl_wr    = 1'b0;
    tick(3);
    check({8'h00, v}, {8'h00, module_control_reg});
  endtask : write_ctrl

  // counts cycles while leg a stays at level v, bounded
  task automatic run_while(input logic v, inout int c);
    while (drv_lvl[3] === v && c < 5000) begin
      tick(1);
      c++;
    end
  endtask : run_while

  // one period from a rising edge of leg a; duty input changed just after it
  task automatic measure(input logic [7:0] new_hi);
    int n;
    n = 0;
    run_while(1'b1, n);
    run_while(1'b0, n);
    check(16'h0000, {8'h00, period_timer});
    duty_high_byte = new_hi;
    hi = 0;
    run_while(1'b1, hi);
    per = hi;
    run_while(1'b0, per);
  endtask : measure

  task automatic wait_irq(inout int c);
    while (module_irq !== 1'b1 && c < 5000) begin
      tick(1);
      c++;
    end
  endtask : wait_irq

  // expected {oe a..d, level a..d} for a steady modulator level m
  function automatic logic [7:0] pin_exp(input logic [1:0] md, input logic [1:0] pol,
                                         input logic m);
    logic pa;
    logic pd;
    pa = m ^ pol[1];
    pd = m ^ pol[0];
    case (md)
      BR_SINGLE:   pin_exp = {4'b1000, pa, 3'b000};
      BR_HALF:     pin_exp = {4'b1100, pa, ~pd, 2'b00};
      BR_FULL_FWD: pin_exp = {4'b1111, ~pol[1], pol[0], pol[1], pd};
      default:     pin_exp = {4'b1111, pol[1], pd, ~pol[1], pol[0]};
    endcase
  endfunction : pin_exp

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // watchdog sized well above the roughly 30k cycles the tests need
  initial begin
    #800000;
    fails++;
    report_and_stop();
  end

  initial begin
    nrst              = 1'b0;
    ctrl_wr           = 1'b0;
    ctrl_wdata        = 8'h00;
    duty_high_byte    = 8'h00;
    period_limit_reg  = 8'h03;
    tmr_prescale_sel  = 2'h0;
    compare_low_byte  = 8'h00;
    compare_high_byte = 8'h00;
    cmp_prescale_sel  = 2'h0;
    adc_enabled       = 1'b0;
    fails             = 0;
    total_checks      = 0;
    void'($urandom(32'h0D8CF6D9));
    tick(20);
    check(16'h0000, {pin_oe, pin_out, module_control_reg});
    nrst = 1'b1;
    tick(1);
    for (int k = 0; k < 32; k++) begin
      duty_high_byte = k[0] ? 8'hFF : 8'h00;
      write_ctrl({k[4:3], k[0], k[0], 2'b11, k[2:1]});
      tick(40);
      exp8 = pin_exp(k[4:3], k[2:1], k[0]);
      check({8'h00, exp8}, {8'h00, pin_oe, pin_out & pin_oe});
    end
    for (int i = 0; i < 4; i++) begin
      // idle first so timer and prescaler restart; last pass takes the slowest prescaler
      write_ctrl(8'h00);
      lim = (i == 0) ? 1 : $urandom_range((i == 3) ? 3 : 15, 1);
      sel = (i == 0) ? 0 : (i == 3) ? 3 : $urandom_range(2, 0);
      f   = 1 << (2 * sel);
      d10 = (i == 0) ? 10'h007 : 10'($urandom_range((lim + 1) * 4 - 1, 1));
      nh  = 8'($urandom_range(lim, 1));
      period_limit_reg = 8'(lim);
      tmr_prescale_sel = 2'(sel);
      duty_high_byte   = d10[9:2];
      write_ctrl({2'b00, d10[1:0], 4'hC});
      measure(d10[9:2]);
      measure(nh);
      check(16'(d10 * f), 16'(hi));
      check(16'((lim + 1) * 4 * f), 16'(per));
      measure(nh);
      check(16'({nh[7:0], d10[1:0]} * f), 16'(hi));
    end
    // reset in mid-run drops the pins and the control value
    nrst = 1'b0;
    tick(2);
    check(16'h0000, {pin_oe, pin_out, module_control_reg});
    nrst = 1'b1;
    tick(1);
    for (int i = 0; i < 2; i++) begin
      cv  = (i == 0) ? 16'h0101 : 16'($urandom_range(40, 2));
      sel = (i == 0) ? $urandom_range(1, 0) : $urandom_range(3, 2);
      {compare_high_byte, compare_low_byte} = cv;
      cmp_prescale_sel = 2'(sel);
      adc_enabled      = ~i[0];
      write_ctrl(8'h0B);
      cnt = 0;
      wait_irq(cnt);
      check({15'h0000, adc_enabled}, {15'h0000, adc_start});
      tick(1);
      check(16'h0000, {15'h0000, module_irq});
      cnt = 1;
      wait_irq(cnt);
      check(16'(cv * (4 << sel)), 16'(cnt));
    end
    // a function code outside the table keeps the block idle
    write_ctrl(8'h05);
    cnt = 0;
    repeat (300) begin
      tick(1);
      if (module_irq !== 1'b0) cnt++;
    end
    check(16'h0000, {8'(cnt), pin_oe, 4'h0});
    report_and_stop();
  end
endmodule : enhanced_pwm_bridge_output_bench

`default_nettype wire
